// [hw/uehs_top.sv]
// endpoint halt status for endpoints 2, 3, 4 and 7, with apb slave
// assumes request decoder strobes and busy levels are on MCLK_I
`timescale 1ns/1ps
`include "uehs_consts.svh"
module uehs_top
   import uehs_pkg::*;
(
   input wire logic MCLK_I,             // 10 mhz usb side clock
   input wire logic RESET_N_I,          // async reset, active low
   input wire logic CE_I,               // clock enable, freezes state
   input wire logic PSEL_I,             // apb select
   input wire logic PENABLE_I,          // apb access phase
   input wire logic PWRITE_I,           // apb direction
   input wire logic [31:0] PADDR_I,     // apb byte address
   input wire logic [31:0] PWDATA_I,    // apb write data
   input wire logic [3:0] PSTRB_I,      // apb byte strobes
   output logic [31:0] PRDATA_O,        // apb read data
   output logic PREADY_O,               // apb ready
   output logic PSLVERR_O,              // apb error, unmapped
   input wire logic [3:0] SET_FEAT_I,   // set_feature halt per ep
   input wire logic [3:0] CLR_FEAT_I,   // clear_feature halt per ep
   input wire logic SET_CFG_I,          // set_configuration seen
   input wire logic [3:0] SET_INTF_I,   // set_interface owning ep
   input wire logic [3:0] EP_ERR_I,     // endpoint error pulse
   input wire logic [3:0] EP_BUSY_I,    // usb access to ep running
   input wire logic [3:0] GET_STATUS_I, // get_status for ep
   output logic [7:0] STATUS_DATA_O,    // status byte to host
   output logic STATUS_VALID_O,         // status byte strobe
   output logic [3:0] HALT_O,           // halt state per ep
   output logic [3:0] TOGGLE_RST_O,     // force next pid to data0
   output logic [3:0] FLUSH_O,          // clear endpoint buffer
   output logic [3:0] NAK_CLR_O,        // clear endpoint nak flag
   output logic NAK_ALL_O,              // control ep nak-all bit
   output logic IRQ_O                   // level interrupt
);

   localparam int NEP = `UEHS_N_EP;
   localparam logic [31:0] EP_OFS [NEP] = '{`UEHS_EP2_OFS,
      `UEHS_EP3_OFS, `UEHS_EP4_OFS, `UEHS_EP7_OFS};

   uehs_top_st_t st;
   uehs_top_st_t next_st;

   logic [NEP-1:0] ep_hit;
   logic [NEP-1:0] halt;
   logic [NEP-1:0] toggle_rst;
   logic [NEP-1:0] flush;
   logic [NEP-1:0] nak_clr;
   logic [NEP-1:0] set_evt;
   logic [NEP-1:0] clr_evt;
   logic [NEP-1:0] ep_wr;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic mapped;
   logic setup;
   logic done;
   logic wr_done;
   logic lane0;
   logic [`UEHS_IRQ_W-1:0] events;
   logic [`UEHS_IRQ_W-1:0] w1c;

   ////////////////////////////////////////////////////////////////////
   // address decode of the own registers
   assign hit_ctrl = (PADDR_I == `UEHS_CTRL_OFS);
   assign hit_stat = (PADDR_I == `UEHS_IRQ_STAT_OFS);
   assign hit_mask = (PADDR_I == `UEHS_IRQ_MASK_OFS);
   assign mapped = (|ep_hit) | hit_ctrl | hit_stat | hit_mask;

   // transfer phases; ready is raised in the first access cycle
   assign setup = PSEL_I & ~PENABLE_I;
   assign done = PSEL_I & PENABLE_I & st.pready;
   assign wr_done = done & PWRITE_I & ~st.pslverr;
   // only the low byte lane carries register data
   assign lane0 = PSTRB_I[0];

   ////////////////////////////////////////////////////////////////////
   // one endpoint instance per halt register
   generate
      for (genvar i = 0; i < NEP; i++) begin : g_ep
         uehs_ep_if eif ();

         assign ep_hit[i] = (PADDR_I == EP_OFS[i]);
         // writes need nak-all set and a full low byte
         assign ep_wr[i] = wr_done & ep_hit[i] & lane0 & st.nak_all;
         assign eif.set_feat = SET_FEAT_I[i];
         assign eif.clr_feat = CLR_FEAT_I[i];
         assign eif.set_cfg = SET_CFG_I;
         assign eif.set_intf = SET_INTF_I[i];
         assign eif.err = EP_ERR_I[i];
         assign eif.busy = EP_BUSY_I[i];
         assign eif.wr_req = ep_wr[i];
         assign eif.wr_bit = PWDATA_I[`UEHS_HALT_BIT];
         assign halt[i] = eif.halt;
         assign toggle_rst[i] = eif.toggle_rst;
         assign flush[i] = eif.flush;
         assign nak_clr[i] = eif.nak_clr;
         assign set_evt[i] = eif.set_evt;
         assign clr_evt[i] = eif.clr_evt;

         uehs_ep u_ep (
            .clk_i(MCLK_I),
            .rst_n_i(RESET_N_I),
            .ce_i(CE_I),
            .p(eif.ep)
         );
      end
   endgenerate

   // low half: stall entered, high half: halt cleared by a request
   assign events = {clr_evt, set_evt};
   assign w1c = (wr_done & hit_stat & lane0) ?
      PWDATA_I[`UEHS_IRQ_W-1:0] : '0;

   ////////////////////////////////////////////////////////////////////
   // register slave, interrupt and status return in one next state
   always_comb begin
      next_st = st;
      // answer in the access phase, never stretched
      next_st.pready = setup;
      if (setup) begin
         next_st.pslverr = ~mapped;
         next_st.prdata = '0;
         for (int i = 0; i < NEP; i++) begin
            if (ep_hit[i]) begin
               // upper bits of the status byte always read zero
               next_st.prdata[`UEHS_HALT_BIT] = halt[i];
            end
         end
         if (hit_ctrl) begin
            next_st.prdata[`UEHS_NAK_ALL_BIT] = st.nak_all;
         end
         if (hit_stat) begin
            next_st.prdata[`UEHS_IRQ_W-1:0] = st.irq_stat;
         end
         if (hit_mask) begin
            next_st.prdata[`UEHS_IRQ_W-1:0] = st.irq_mask;
         end
      end else if (done) begin
         next_st.pslverr = 1'b0;
      end
      // own control and mask registers also take only whole bytes
      if (wr_done && lane0 && hit_ctrl) begin
         next_st.nak_all = PWDATA_I[`UEHS_NAK_ALL_BIT];
      end
      if (wr_done && lane0 && hit_mask) begin
         next_st.irq_mask = PWDATA_I[`UEHS_IRQ_W-1:0];
      end
      // a new event wins over a clear written in the same cycle
      next_st.irq_stat = (st.irq_stat & ~w1c) | events;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      // status return to the host; lowest endpoint wins a tie
      next_st.status_valid = |GET_STATUS_I;
      next_st.status_data = '0;
      for (int i = NEP - 1; i >= 0; i--) begin
         if (GET_STATUS_I[i]) begin
            next_st.status_data = {7'h00, halt[i]};
         end
      end
   end

   // single state register, frozen while the enable is low
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st <= '0;
      end else if (CE_I) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // every output is a flip-flop of this module or of an endpoint
   assign PRDATA_O = st.prdata;
   assign PREADY_O = st.pready;
   assign PSLVERR_O = st.pslverr;
   assign STATUS_DATA_O = st.status_data;
   assign STATUS_VALID_O = st.status_valid;
   assign NAK_ALL_O = st.nak_all;
   assign IRQ_O = st.irq;
   assign HALT_O = halt;
   assign TOGGLE_RST_O = toggle_rst;
   assign FLUSH_O = flush;
   assign NAK_CLR_O = nak_clr;

endmodule

// [hw/uehs_consts.svh]
// constants for the endpoint halt status block: offsets, fields, resets
// assumes inclusion by bare name from the package and the design modules
`ifndef UEHS_CONSTS_SVH
`define UEHS_CONSTS_SVH

`define UEHS_N_EP 4
`define UEHS_EP2_OFS 32'h0020_0154
`define UEHS_EP3_OFS 32'h0020_0158
`define UEHS_EP4_OFS 32'h0020_015C
`define UEHS_EP7_OFS 32'h0020_0168
`define UEHS_CTRL_OFS 32'h0020_0300
`define UEHS_IRQ_STAT_OFS 32'h0020_0304
`define UEHS_IRQ_MASK_OFS 32'h0020_0308
`define UEHS_HALT_BIT 0
`define UEHS_NAK_ALL_BIT 0
`define UEHS_IRQ_W 8
`define UEHS_STAT_RST 8'h00
`define UEHS_CTRL_RST 1'h0
`define UEHS_IRQ_RST 8'h00

`endif

// [hw/uehs_pkg.sv]
// types for the endpoint halt status block
// assumes the constants header is on the include path
`include "uehs_consts.svh"
package uehs_pkg;

   // state of one endpoint's halt logic
   typedef struct packed {
      logic halt;
      logic toggle_rst;
      logic flush;
      logic nak_clr;
      logic set_evt;
      logic clr_evt;
   } uehs_ep_st_t;

   // state of the register slave and status return
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic nak_all;
      logic [`UEHS_IRQ_W-1:0] irq_stat;
      logic [`UEHS_IRQ_W-1:0] irq_mask;
      logic irq;
      logic [7:0] status_data;
      logic status_valid;
   } uehs_top_st_t;

endpackage

// [hw/uehs_ep_if.sv]
// signals between the register slave and one endpoint's halt logic
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface uehs_ep_if;
   logic set_feat;
   logic clr_feat;
   logic set_cfg;
   logic set_intf;
   logic err;
   logic busy;
   logic wr_req;
   logic wr_bit;
   logic halt;
   logic toggle_rst;
   logic flush;
   logic nak_clr;
   logic set_evt;
   logic clr_evt;

   modport ctrl (output set_feat, clr_feat, set_cfg, set_intf, err, busy,
      wr_req, wr_bit, input halt, toggle_rst, flush, nak_clr, set_evt,
      clr_evt);
   modport ep (input set_feat, clr_feat, set_cfg, set_intf, err, busy,
      wr_req, wr_bit, output halt, toggle_rst, flush, nak_clr, set_evt,
      clr_evt);
endinterface

// [hw/uehs_ep.sv]
// halt state of one non-control endpoint
// assumes request strobes are one-cycle pulses on the same clock
`timescale 1ns/1ps
module uehs_ep
   import uehs_pkg::*;
(
   input wire logic clk_i,   // usb side clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic ce_i,    // clock enable
   uehs_ep_if.ep p           // link to the register slave
);

   uehs_ep_st_t st;
   uehs_ep_st_t next_st;
   logic clr_req;
   logic set_req;

   ////////////////////////////////////////////////////////////////////
   // hardware requests beat cpu writes; a set beats a clear so that
   // an error arriving with a clear is never lost
   always_comb begin
      next_st = st;
      clr_req = p.clr_feat | p.set_cfg | p.set_intf;
      set_req = p.set_feat | p.err;
      if (set_req) begin
         next_st.halt = 1'b1;
      end else if (clr_req) begin
         next_st.halt = 1'b0;
      end else if (p.wr_req && !p.busy) begin
         next_st.halt = p.wr_bit;
      end
      next_st.toggle_rst = clr_req;
      // entry into stall empties the buffer and drops its nak
      next_st.flush = next_st.halt & ~st.halt;
      next_st.nak_clr = next_st.halt & ~st.halt;
      next_st.set_evt = next_st.halt & ~st.halt;
      next_st.clr_evt = clr_req & ~set_req & st.halt;
   end

   // one register stage for the whole endpoint, frozen by enable
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign p.halt = st.halt;
   assign p.toggle_rst = st.toggle_rst;
   assign p.flush = st.flush;
   assign p.nak_clr = st.nak_clr;
   assign p.set_evt = st.set_evt;
   assign p.clr_evt = st.clr_evt;

endmodule

// [verification/uehs_halt_monitor.sv]
// assertions on the halt status block's ports
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/1ps
`include "uehs_consts.svh"
module uehs_halt_monitor (
   input wire logic MCLK_I, RESET_N_I, CE_I, // clock, reset, enable
   input wire logic PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, // apb
   input wire logic [31:0] PADDR_I, // apb address
   input wire logic [3:0] SET_FEAT_I, CLR_FEAT_I, SET_INTF_I, // requests
   input wire logic [3:0] EP_ERR_I, EP_BUSY_I, GET_STATUS_I, // usb side
   input wire logic SET_CFG_I, STATUS_VALID_O, NAK_ALL_O, // misc
   input wire logic [7:0] STATUS_DATA_O, // status byte
   input wire logic [3:0] HALT_O, TOGGLE_RST_O, FLUSH_O, NAK_CLR_O // per ep
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   logic [3:0] set_q, clr_q;
   logic gs_q;
   ////////////////////////////////////////////////////////////////////////
   // requests of last cycle; set wins, so a clear beside a set is dropped
   // a request seen while the enable is low is lost, so it is not expected
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         set_q <= 4'h0;
         clr_q <= 4'h0;
         gs_q <= 1'h0;
      end else begin
         set_q <= (SET_FEAT_I | EP_ERR_I) & {4{CE_I}};
         clr_q <= (CLR_FEAT_I | SET_INTF_I | {4{SET_CFG_I}})
            & ~(SET_FEAT_I | EP_ERR_I) & {4{CE_I}};
         gs_q <= GET_STATUS_I[0] ? HALT_O[0] : GET_STATUS_I[1] ? HALT_O[1]
            : GET_STATUS_I[2] ? HALT_O[2] : HALT_O[3];
      end
   end
   sequence apb_setup; PSEL_I && !PENABLE_I; endsequence
   sequence apb_write; PSEL_I && PENABLE_I && PWRITE_I && PREADY_O; endsequence
   sequence quiet;
      !SET_CFG_I && (SET_FEAT_I | CLR_FEAT_I | SET_INTF_I | EP_ERR_I) == 4'h0;
   endsequence
   ready_once_a: assert property (apb_setup |=> PREADY_O ##1 !PREADY_O)
      else $error("ready not a single cycle");
   set_halt_a: assert property (|set_q |-> (HALT_O & set_q) == set_q)
      else $error("halt not set");
   clr_halt_a: assert property (|clr_q |-> (HALT_O & clr_q) == 4'h0)
      else $error("halt not cleared");
   toggle_rst_a: assert property (|clr_q |->
      (TOGGLE_RST_O & clr_q) == clr_q) else $error("toggle not reset");
   flush_a: assert property (
      FLUSH_O == (HALT_O & ~$past(HALT_O)))
      else $error("flush not on stall entry");
   nak_clr_a: assert property (NAK_CLR_O == FLUSH_O)
      else $error("nak clear differs from flush");
   status_a: assert property (|GET_STATUS_I |=> STATUS_VALID_O
      && STATUS_DATA_O == {7'h00, gs_q}) else $error("status byte wrong");
   status_cause_a: assert property (STATUS_VALID_O |->
      $past(GET_STATUS_I) != 4'h0) else $error("status without request");
   gate_nak_a: assert property (apb_write ##0 quiet ##0 !NAK_ALL_O
      |=> $stable(HALT_O)) else $error("write taken without nak-all");
   gate_busy_a: assert property (apb_write ##0 quiet ##0
      (PADDR_I == `UEHS_EP2_OFS && EP_BUSY_I[0]) |=> $stable(HALT_O[0]))
      else $error("write taken while endpoint busy");
endmodule

// [verification/uehs_host_model.sv]
// usb host side: request pulses, busy levels, status byte capture
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module uehs_host_model (
   input wire logic clk_i, // block clock
   input wire logic [7:0] status_data_i, // status byte
   input wire logic status_valid_i, // status strobe
   output logic [3:0] set_feat_o, clr_feat_o, set_intf_o, // requests
   output logic [3:0] err_o, busy_o, get_status_o, // endpoint events
   output logic set_cfg_o // set_configuration seen
);
   logic [7:0] last_status;
   initial begin
      {set_feat_o, clr_feat_o, set_intf_o, err_o, busy_o} = 20'h0;
      get_status_o = 4'h0;
      set_cfg_o = 1'h0;
      last_status = 8'hAA;
   end
   ////////////////////////////////////////////////////////////////////////
   // one request kind for one cycle; kind 6 moves the busy level instead
   task automatic req(input int k, input logic [3:0] m);
      @(posedge clk_i);
      case (k)
         0: set_feat_o <= m;
         1: clr_feat_o <= m;
         2: set_intf_o <= m;
         3: set_cfg_o <= m[0];
         4: err_o <= m;
         5: get_status_o <= m;
         default: busy_o <= m;
      endcase
      if (k < 6) begin
         @(posedge clk_i);
         {set_feat_o, clr_feat_o, set_intf_o, err_o, get_status_o} <= 20'h0;
         set_cfg_o <= 1'h0;
      end
   endtask
   // byte taken only in the cycle its strobe stands
   always @(posedge clk_i) begin
      if (status_valid_i === 1'h1) last_status <= status_data_i;
   end
endmodule

// [verification/usb_endpoint_halt_status_tb.sv]
// self-checking bench for the endpoint halt status block
// assumes monitor and host model are compiled before it
`timescale 1ns/1ps
`include "uehs_consts.svh"
module usb_endpoint_halt_status_tb;
   logic MCLK_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I, slv_err;
   logic [31:0] PADDR_I, PWDATA_I, PRDATA_O, rd;
   logic PREADY_O, PSLVERR_O, SET_CFG_I, STATUS_VALID_O, NAK_ALL_O, IRQ_O;
   logic [3:0] SET_FEAT_I, CLR_FEAT_I, SET_INTF_I, EP_ERR_I, EP_BUSY_I;
   logic [3:0] GET_STATUS_I, HALT_O, TOGGLE_RST_O, FLUSH_O, NAK_CLR_O;
   logic [7:0] STATUS_DATA_O;
   logic [3:0] strb;
   logic ce;
   logic [31:0] ofs [4] = '{`UEHS_EP2_OFS, `UEHS_EP3_OFS, `UEHS_EP4_OFS,
      `UEHS_EP7_OFS};
   int mismatches = 0;
   int tests_run = 0;
   uehs_top uut (.MCLK_I, .RESET_N_I, .CE_I(ce), .PSEL_I, .PENABLE_I,
      .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I(strb), .PRDATA_O, .PREADY_O,
      .PSLVERR_O, .SET_FEAT_I, .CLR_FEAT_I, .SET_CFG_I, .SET_INTF_I,
      .EP_ERR_I, .EP_BUSY_I, .GET_STATUS_I, .STATUS_DATA_O, .STATUS_VALID_O,
      .HALT_O, .TOGGLE_RST_O, .FLUSH_O, .NAK_CLR_O, .NAK_ALL_O, .IRQ_O);
   uehs_host_model host (.clk_i(MCLK_I), .status_data_i(STATUS_DATA_O),
      .status_valid_i(STATUS_VALID_O), .set_feat_o(SET_FEAT_I),
      .clr_feat_o(CLR_FEAT_I), .set_intf_o(SET_INTF_I), .err_o(EP_ERR_I),
      .busy_o(EP_BUSY_I), .get_status_o(GET_STATUS_I), .set_cfg_o(SET_CFG_I));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // apb master: request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [31:0] a, d);
      @(posedge MCLK_I);
      PSEL_I <= 1'h1;
      PENABLE_I <= 1'h0;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I);
      PENABLE_I <= 1'h1;
      @(posedge MCLK_I);
      while (PREADY_O !== 1'h1) @(posedge MCLK_I);
      rd = PRDATA_O;
      slv_err = PSLVERR_O;
      PSEL_I <= 1'h0;
      PENABLE_I <= 1'h0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge MCLK_I);
   endtask
   task automatic close_out;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      MCLK_I = 1'h0;
      forever #50 MCLK_I = ~MCLK_I;
   end
   // hang guard at 5000 cycles, far beyond the under 200 cycles the tests need
   initial begin
      #500000;
      mismatches++;
      close_out;
   end
   initial begin
      {RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I} = 4'h0;
      PADDR_I = 32'h0;
      PWDATA_I = 32'h0;
      strb = 4'hF;
      ce = 1'h1;
      tick(3);
      RESET_N_I <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'h0, 32'h0020_0160, 32'h0);
      chk({31'h0, slv_err}, 32'h1);
      // write dropped while nak-all is clear
      apb(1'h1, ofs[0], 32'hFF);
      apb(1'h0, ofs[0], 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, `UEHS_CTRL_OFS, 32'h1);
      apb(1'h0, `UEHS_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, NAK_ALL_O}, 32'h1);
      // write without the low byte lane is dropped
      strb <= 4'hE;
      apb(1'h1, ofs[1], 32'hFF);
      strb <= 4'hF;
      apb(1'h0, ofs[1], 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, ofs[i], 32'hFF);
         apb(1'h0, ofs[i], 32'h0);
         chk(rd, 32'h1);
         apb(1'h1, ofs[i], 32'h0);
         apb(1'h0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      // usb access on ep2 blocks the cpu write
      host.req(6, 4'h1);
      apb(1'h1, ofs[0], 32'h1);
      apb(1'h0, ofs[0], 32'h0);
      chk(rd, 32'h0);
      host.req(6, 4'h0);
      // enable low freezes state, so an error pulse then is lost
      ce <= 1'h0;
      host.req(4, 4'h1);
      ce <= 1'h1;
      tick(1);
      chk({28'h0, HALT_O}, 32'h0);
      // error on ep2 alone, interrupt raised then cleared
      apb(1'h1, `UEHS_IRQ_STAT_OFS, 32'hFF);
      apb(1'h1, `UEHS_IRQ_MASK_OFS, 32'h1);
      host.req(4, 4'h1);
      tick(3);
      chk({28'h0, HALT_O}, 32'h1);
      chk({31'h0, IRQ_O}, 32'h1);
      apb(1'h1, `UEHS_IRQ_STAT_OFS, 32'hFF);
      tick(2);
      chk({31'h0, IRQ_O}, 32'h0);
      for (int i = 1; i < 4; i++) host.req(4, 4'h1 << i);
      tick(3);
      chk({28'h0, HALT_O}, 32'hF);
      chk({31'h0, IRQ_O}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         host.req(5, 4'h1 << i);
         tick(2);
         chk(host.last_status, 32'h1);
      end
      // clearing requests, then a set
      host.req(1, 4'h1);
      tick(1);
      chk({28'h0, HALT_O}, 32'hE);
      host.req(5, 4'h1);
      tick(2);
      chk(host.last_status, 32'h0);
      host.req(2, 4'h2);
      tick(1);
      chk({28'h0, HALT_O}, 32'hC);
      host.req(3, 4'h1);
      tick(1);
      chk({28'h0, HALT_O}, 32'h0);
      host.req(0, 4'h8);
      apb(1'h0, ofs[3], 32'h0);
      chk(rd, 32'h1);
      // stall entries on ep3/4/7, clears by request on all four
      apb(1'h0, `UEHS_IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'hFE);
      // reset in mid-run clears the halt state
      RESET_N_I <= 1'h0;
      tick(2);
      RESET_N_I <= 1'h1;
      apb(1'h0, ofs[3], 32'h0);
      chk(rd, 32'h0);
      close_out;
   end
endmodule
bind uehs_top uehs_halt_monitor mon (.MCLK_I, .RESET_N_I, .CE_I, .PSEL_I,
   .PENABLE_I, .PWRITE_I, .PREADY_O, .PADDR_I, .SET_FEAT_I, .CLR_FEAT_I,
   .SET_INTF_I, .EP_ERR_I, .EP_BUSY_I, .GET_STATUS_I, .SET_CFG_I,
   .STATUS_VALID_O, .NAK_ALL_O, .STATUS_DATA_O, .HALT_O, .TOGGLE_RST_O,
   .FLUSH_O, .NAK_CLR_O);
